// ---- hdl/cmp_back_end.sv ----
// Notes on behaviour
// - Sync enable 1 latches comparator B on counter clock fall; 0 passes.
// - One register mirrors both comparator outputs for a skew-free read.
// - Reading the mirror register never refreshes the mismatch latches.
// - Gate select 1 picks the gate pin, 0 the synced comparator B.
// - Comparator output bits are read-only; writes leave them unchanged.
// - Routed pin carries the comparator output instead of the port latch.
// - The pin direction bit stays the output enable while routed.
// - A polarity bit per comparator inverts its output for every use.
// - With a prescaler the sync latch uses the prescaled counter clock.
// - Capture on counter clock fall; the counter counts on the rise.
// - Flag sets on the edge where output first differs from latch.
// - Writing 0 clears a flag; writing 1 sets it as a soft interrupt.
// - Interrupt needs flag, its enable, peripheral and global enables.
// - Unrefreshed latch: return gives no flag; refreshed: return flags.
// - A change coinciding with a register read may miss its flag; this design still sets the flag.
// - Reset returns every register, disabling both comparators.
//
// Decided for this implementation: the register offsets and the APB slave port.
module cmp_back_end (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Analog comparators
  input  wire logic        CMP_A_RAW,
  input  wire logic        CMP_B_RAW,
  output logic             CMP_A_EN,
  output logic             CMP_B_EN,
  // Gated counter
  input  wire logic        CNT_CLK_RAW,
  input  wire logic        CNT_CLK_PRESC,
  input  wire logic        CNT_PRESCALE_ON,
  input  wire logic        COUNTER_GATE_PIN,
  output logic             COUNTER_GATE,
  // Comparator pins
  output logic             CMP_A_PIN_O,
  output logic             CMP_A_PIN_OE,
  output logic             CMP_B_PIN_O,
  output logic             CMP_B_PIN_OE,
  // Interrupt to the processor
  output logic             IRQ
);

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  // ==========================================================================
  // Address decode helper
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = (addr[7:2] == ofs[7:2]);
  endfunction

  // ==========================================================================
  // Register state
  logic                gie_q;
  logic                peripheral_irq_enable_q;
  logic [1:0]          irq_en_q;
  logic [1:0]          irq_flag_q;
  logic [1:0]          irq_flag_d;
  logic                gate_sel_q;
  logic                sync_en_q;
  cmp_pkg::cmp_cfg_t   cfg_q;
  cmp_pkg::pin_cfg_t   pin_q;

  // Bus handshake
  logic                pready_q;
  logic                pslverr_q;
  logic [31:0]         prdata_q;
  logic                setup;
  logic                acc;
  logic                wr;
  logic                rd;
  logic                mapped;

  // Input synchronisers
  logic [4:0]          meta_q;
  logic [4:0]          sync_q;
  logic                cmp_a_out;
  logic                cmp_b_out;
  logic                cclk;
  logic                cclk_prev_q;
  logic                cclk_fall;

  // Comparator B sync latch and gate
  logic                sync_latch_q;
  logic                cmp_b_synced_output;
  logic                gate_q;

  // Mismatch detection
  logic [1:0]          mm_q;
  logic [1:0]          mism_prev_q;
  logic [1:0]          mismatch_now;
  logic [1:0]          mism_rise;
  logic                refresh;

  // Registered outputs
  logic                irq_q;
  logic                pin_a_o_q;
  logic                pin_a_oe_q;
  logic                pin_b_o_q;
  logic                pin_b_oe_q;

  // ==========================================================================
  // APB slave: zero wait states, error on unmapped words
  assign setup  = PSEL & ~PENABLE;
  assign acc    = PSEL & PENABLE & pready_q;
  assign wr     = acc & PWRITE;
  assign rd     = acc & ~PWRITE;
  assign mapped = hit(PADDR, cmp_pkg::GLOBAL_IRQ_OFS)
                | hit(PADDR, cmp_pkg::PERIPH_IE_OFS)
                | hit(PADDR, cmp_pkg::PERIPH_IF_OFS)
                | hit(PADDR, cmp_pkg::MIRROR_OFS)
                | hit(PADDR, cmp_pkg::CMP_CTRL_OFS)
                | hit(PADDR, cmp_pkg::PIN_CTRL_OFS);

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
    end
  end

  // Read data is captured in the setup cycle so that it leaves a flop.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= 32'h0000_0000;
      if (hit(PADDR, cmp_pkg::GLOBAL_IRQ_OFS)) begin
        prdata_q[cmp_pkg::GIE_BIT]  <= gie_q;
        prdata_q[cmp_pkg::PERIPHERAL_IRQ_ENABLE_BIT] <= peripheral_irq_enable_q;
      end
      if (hit(PADDR, cmp_pkg::PERIPH_IE_OFS)) begin
        prdata_q[cmp_pkg::CMP_B_IRQ_BIT] <= irq_en_q[1];
        prdata_q[cmp_pkg::CMP_A_IRQ_BIT] <= irq_en_q[0];
      end
      if (hit(PADDR, cmp_pkg::PERIPH_IF_OFS)) begin
        prdata_q[cmp_pkg::CMP_B_IRQ_BIT] <= irq_flag_q[1];
        prdata_q[cmp_pkg::CMP_A_IRQ_BIT] <= irq_flag_q[0];
      end
      if (hit(PADDR, cmp_pkg::MIRROR_OFS)) begin
        prdata_q[cmp_pkg::MIRROR_A_BIT] <= cmp_a_out;
        prdata_q[cmp_pkg::MIRROR_B_BIT] <= cmp_b_out;
        prdata_q[cmp_pkg::GATE_SEL_BIT] <= gate_sel_q;
        prdata_q[cmp_pkg::SYNC_EN_BIT]  <= sync_en_q;
      end
      if (hit(PADDR, cmp_pkg::CMP_CTRL_OFS)) begin
        prdata_q[cmp_pkg::OUT_B_BIT] <= cmp_b_out;
        prdata_q[cmp_pkg::OUT_A_BIT] <= cmp_a_out;
        prdata_q[cmp_pkg::POL_B_BIT] <= cfg_q.b_pol;
        prdata_q[cmp_pkg::POL_A_BIT] <= cfg_q.a_pol;
        prdata_q[cmp_pkg::EN_B_BIT]  <= cfg_q.b_en;
        prdata_q[cmp_pkg::EN_A_BIT]  <= cfg_q.a_en;
      end
      if (hit(PADDR, cmp_pkg::PIN_CTRL_OFS)) begin
        prdata_q[cmp_pkg::DIR_B_BIT]   <= pin_q.b_dir;
        prdata_q[cmp_pkg::DIR_A_BIT]   <= pin_q.a_dir;
        prdata_q[cmp_pkg::DATA_B_BIT]  <= pin_q.b_data;
        prdata_q[cmp_pkg::DATA_A_BIT]  <= pin_q.a_data;
        prdata_q[cmp_pkg::ROUTE_B_BIT] <= pin_q.b_route;
        prdata_q[cmp_pkg::ROUTE_A_BIT] <= pin_q.a_route;
      end
    end
  end

  // ==========================================================================
  // Writable configuration
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      gie_q      <= cmp_pkg::GIE_RST;
      peripheral_irq_enable_q     <= cmp_pkg::PERIPHERAL_IRQ_ENABLE_RST;
      irq_en_q   <= cmp_pkg::IE_RST;
      gate_sel_q <= cmp_pkg::GATE_SEL_RST;
      sync_en_q  <= cmp_pkg::SYNC_EN_RST;
      cfg_q      <= cmp_pkg::CMP_CFG_RST;
      pin_q      <= cmp_pkg::PIN_CFG_RST;
    end else if (wr) begin
      if (hit(PADDR, cmp_pkg::GLOBAL_IRQ_OFS)) begin
        gie_q  <= PWDATA[cmp_pkg::GIE_BIT];
        peripheral_irq_enable_q <= PWDATA[cmp_pkg::PERIPHERAL_IRQ_ENABLE_BIT];
      end
      if (hit(PADDR, cmp_pkg::PERIPH_IE_OFS)) begin
        irq_en_q <= {PWDATA[cmp_pkg::CMP_B_IRQ_BIT],
                     PWDATA[cmp_pkg::CMP_A_IRQ_BIT]};
      end
      // Mirror bits have no storage, so a write cannot alter them.
      if (hit(PADDR, cmp_pkg::MIRROR_OFS)) begin
        gate_sel_q <= PWDATA[cmp_pkg::GATE_SEL_BIT];
        sync_en_q  <= PWDATA[cmp_pkg::SYNC_EN_BIT];
      end
      if (hit(PADDR, cmp_pkg::CMP_CTRL_OFS)) begin
        cfg_q.a_en  <= PWDATA[cmp_pkg::EN_A_BIT];
        cfg_q.b_en  <= PWDATA[cmp_pkg::EN_B_BIT];
        cfg_q.a_pol <= PWDATA[cmp_pkg::POL_A_BIT];
        cfg_q.b_pol <= PWDATA[cmp_pkg::POL_B_BIT];
      end
      if (hit(PADDR, cmp_pkg::PIN_CTRL_OFS)) begin
        pin_q.a_route <= PWDATA[cmp_pkg::ROUTE_A_BIT];
        pin_q.b_route <= PWDATA[cmp_pkg::ROUTE_B_BIT];
        pin_q.a_data  <= PWDATA[cmp_pkg::DATA_A_BIT];
        pin_q.b_data  <= PWDATA[cmp_pkg::DATA_B_BIT];
        pin_q.a_dir   <= PWDATA[cmp_pkg::DIR_A_BIT];
        pin_q.b_dir   <= PWDATA[cmp_pkg::DIR_B_BIT];
      end
    end
  end

  // ==========================================================================
  // Input synchronisers and polarity
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      meta_q <= 5'h00;
      sync_q <= 5'h00;
    end else begin
      meta_q <= {CNT_CLK_PRESC, CNT_CLK_RAW, COUNTER_GATE_PIN,
                 CMP_B_RAW, CMP_A_RAW};
      sync_q <= meta_q;
    end
  end

  // A disabled comparator reads as zero whatever its polarity.
  assign cmp_a_out = cfg_q.a_en & (sync_q[0] ^ cfg_q.a_pol);
  assign cmp_b_out = cfg_q.b_en & (sync_q[1] ^ cfg_q.b_pol);

  // ==========================================================================
  // Comparator B synchronisation to the counter clock
  // The counter counts on the rising edge, so the capture on the falling
  // edge keeps the gate steady across each increment.
  assign cclk      = CNT_PRESCALE_ON ? sync_q[4] : sync_q[3];
  assign cclk_fall = cclk_prev_q & ~cclk;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      cclk_prev_q  <= 1'b0;
      sync_latch_q <= 1'b0;
    end else begin
      cclk_prev_q <= cclk;
      if (cclk_fall) begin
        sync_latch_q <= cmp_b_out;
      end
    end
  end

  assign cmp_b_synced_output = sync_en_q ? sync_latch_q : cmp_b_out;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_sel_q ? sync_q[2] : cmp_b_synced_output;
    end
  end

  // ==========================================================================
  // Mismatch latches and edge-set flags
  // Only an access to the comparator control word refreshes the latches.
  assign refresh      = acc & hit(PADDR, cmp_pkg::CMP_CTRL_OFS);
  assign mismatch_now = {cmp_b_out, cmp_a_out} ^ mm_q;
  assign mism_rise    = mismatch_now & ~mism_prev_q;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      mm_q        <= 2'h0;
      mism_prev_q <= 2'h0;
    end else begin
      // After a refresh the old level counts as a change again.
      if (refresh) begin
        mm_q        <= {cmp_b_out, cmp_a_out};
        mism_prev_q <= 2'h0;
      end else begin
        mism_prev_q <= mismatch_now;
      end
    end
  end

  // A hardware set in the same cycle as a software clear wins, so the
  // read race that may drop a flag is not present here.
  always_comb begin
    irq_flag_d = irq_flag_q;
    if (wr && hit(PADDR, cmp_pkg::PERIPH_IF_OFS)) begin
      irq_flag_d = {PWDATA[cmp_pkg::CMP_B_IRQ_BIT],
                    PWDATA[cmp_pkg::CMP_A_IRQ_BIT]};
    end
    irq_flag_d = irq_flag_d | mism_rise;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      irq_flag_q <= cmp_pkg::IF_RST;
    end else begin
      irq_flag_q <= irq_flag_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= gie_q & peripheral_irq_enable_q & (|(irq_flag_q & irq_en_q));
    end
  end

  // ==========================================================================
  // Pin multiplexers
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pin_a_o_q  <= 1'b0;
      pin_b_o_q  <= 1'b0;
      pin_a_oe_q <= 1'b0;
      pin_b_oe_q <= 1'b0;
    end else begin
      pin_a_o_q  <= pin_q.a_route ? cmp_a_out : pin_q.a_data;
      pin_b_o_q  <= pin_q.b_route ? cmp_b_out : pin_q.b_data;
      pin_a_oe_q <= ~pin_q.a_dir;
      pin_b_oe_q <= ~pin_q.b_dir;
    end
  end

  assign PRDATA       = prdata_q;
  assign PREADY       = pready_q;
  assign PSLVERR      = pslverr_q;
  assign CMP_A_EN     = cfg_q.a_en;
  assign CMP_B_EN     = cfg_q.b_en;
  assign COUNTER_GATE = gate_q;
  assign CMP_A_PIN_O  = pin_a_o_q;
  assign CMP_A_PIN_OE = pin_a_oe_q;
  assign CMP_B_PIN_O  = pin_b_o_q;
  assign CMP_B_PIN_OE = pin_b_oe_q;
  assign IRQ          = irq_q;

  // ==========================================================================
  // Checks
  sequence s_fall_capture;
    sync_en_q && cclk_fall;
  endsequence

  sequence s_mirror_read;
    setup && !PWRITE && hit(PADDR, cmp_pkg::MIRROR_OFS);
  endsequence

  a_sync_capture: assert property (
    s_fall_capture ##1 (sync_en_q && !cclk_fall)
      |-> cmp_b_synced_output == $past(cmp_b_out)
  ) else $error("synced output missed the falling-edge capture");

  a_async_pass: assert property (
    !sync_en_q |-> cmp_b_synced_output == cmp_b_out
  ) else $error("unsynchronised output differs from comparator");

  a_mirror_values: assert property (
    s_mirror_read |=> PREADY
      && PRDATA[cmp_pkg::MIRROR_A_BIT] == $past(cmp_a_out)
      && PRDATA[cmp_pkg::MIRROR_B_BIT] == $past(cmp_b_out)
  ) else $error("mirror read does not show both outputs");

  a_mirror_quiet: assert property (
    (rd && hit(PADDR, cmp_pkg::MIRROR_OFS)) |=> $stable(mm_q)
  ) else $error("mirror read touched the mismatch latches");

  a_gate_source: assert property (
    ##1 COUNTER_GATE == ($past(gate_sel_q) ? $past(sync_q[2])
                                           : $past(cmp_b_synced_output))
  ) else $error("counter gate from the wrong source");

  a_pin_drive: assert property (
    pin_q.a_route && $stable(cmp_a_out) [*2]
      |-> CMP_A_PIN_O == cmp_a_out && CMP_A_PIN_OE == !$past(pin_q.a_dir)
  ) else $error("routed pin does not carry comparator output");

  a_polarity_off: assert property (
    !cfg_q.b_en |-> !cmp_b_out ##1 (cfg_q.b_en || PRDATA[31:8] == 24'h000000)
  ) else $error("disabled comparator reads other than zero");

  a_flag_edge: assert property (
    mism_rise[0] |=> irq_flag_q[0]
  ) else $error("mismatch edge did not set the flag");

  a_flag_level: assert property (
    (wr && hit(PADDR, cmp_pkg::PERIPH_IF_OFS)
       && !PWDATA[cmp_pkg::CMP_A_IRQ_BIT] && mism_prev_q[0]
       && mismatch_now[0])
      |=> !irq_flag_q[0]
  ) else $error("flag set again by a steady mismatch level");

  a_soft_set: assert property (
    (wr && hit(PADDR, cmp_pkg::PERIPH_IF_OFS)
       && PWDATA[cmp_pkg::CMP_B_IRQ_BIT]) |=> irq_flag_q[1] ##1
      IRQ == ($past(gie_q) && $past(peripheral_irq_enable_q)
              && |($past(irq_flag_q) & $past(irq_en_q)))
  ) else $error("software write of one did not set the flag");

  a_irq_gate: assert property (
    ##1 IRQ == ($past(gie_q) && $past(peripheral_irq_enable_q)
                && |($past(irq_flag_q) & $past(irq_en_q)))
  ) else $error("interrupt line disagrees with flags and enables");

  a_refresh_take: assert property (
    refresh |=> mm_q == {$past(cmp_b_out), $past(cmp_a_out)}
  ) else $error("refresh did not load the current outputs");

  a_reset_state: assert property (disable iff (1'b0)
    SRST |=> !CMP_A_EN && !CMP_B_EN && irq_flag_q == 2'h0 && !IRQ
  ) else $error("reset left a comparator or flag active");

endmodule

// ---- hdl/cmp_pkg.sv ----
package cmp_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // ==========================================================================
  // Register byte addresses, one aligned word each
  localparam logic [7:0] GLOBAL_IRQ_OFS = 8'h00;
  localparam logic [7:0] PERIPH_IE_OFS  = 8'h04;
  localparam logic [7:0] PERIPH_IF_OFS  = 8'h08;
  localparam logic [7:0] MIRROR_OFS     = 8'h0c;
  localparam logic [7:0] CMP_CTRL_OFS   = 8'h10;
  localparam logic [7:0] PIN_CTRL_OFS   = 8'h14;

  // ==========================================================================
  // Field positions
  localparam int unsigned GIE_BIT       = 7;
  localparam int unsigned PERIPHERAL_IRQ_ENABLE_BIT      = 6;
  localparam int unsigned CMP_B_IRQ_BIT = 4;
  localparam int unsigned CMP_A_IRQ_BIT = 3;
  localparam int unsigned MIRROR_A_BIT  = 7;
  localparam int unsigned MIRROR_B_BIT  = 6;
  localparam int unsigned GATE_SEL_BIT  = 1;
  localparam int unsigned SYNC_EN_BIT   = 0;
  localparam int unsigned OUT_B_BIT     = 7;
  localparam int unsigned OUT_A_BIT     = 6;
  localparam int unsigned POL_B_BIT     = 5;
  localparam int unsigned POL_A_BIT     = 4;
  localparam int unsigned EN_B_BIT      = 1;
  localparam int unsigned EN_A_BIT      = 0;
  localparam int unsigned DIR_B_BIT     = 5;
  localparam int unsigned DIR_A_BIT     = 4;
  localparam int unsigned DATA_B_BIT    = 3;
  localparam int unsigned DATA_A_BIT    = 2;
  localparam int unsigned ROUTE_B_BIT   = 1;
  localparam int unsigned ROUTE_A_BIT   = 0;

  // ==========================================================================
  // Reset values
  localparam logic       GIE_RST      = 1'b0;
  localparam logic       PERIPHERAL_IRQ_ENABLE_RST     = 1'b0;
  localparam logic [1:0] IE_RST       = 2'h0;
  localparam logic [1:0] IF_RST       = 2'h0;
  localparam logic       GATE_SEL_RST = 1'b1;
  localparam logic       SYNC_EN_RST  = 1'b0;
  localparam logic [1:0] DIR_RST      = 2'h3;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic a_en;
    logic b_en;
    logic a_pol;
    logic b_pol;
  } cmp_cfg_t;

  typedef struct packed {
    logic a_route;
    logic b_route;
    logic a_data;
    logic b_data;
    logic a_dir;
    logic b_dir;
  } pin_cfg_t;

  localparam cmp_cfg_t CMP_CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0};
  localparam pin_cfg_t PIN_CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0,
                                       DIR_RST[0], DIR_RST[1]};

endpackage

// ---- tb/analog_partner.sv ----
// ============================================================================
// Analog comparators and the counter clock source
module analog_partner (
  // Comparator side
  input  wire logic en_a,
  input  wire logic en_b,
  input  wire logic lvl_a,
  input  wire logic lvl_b,
  output logic      raw_a,
  output logic      raw_b,
  // Counter clocks
  input  wire logic run_raw,
  input  wire logic run_presc,
  output logic      cnt_raw,
  output logic      cnt_presc
);
  timeunit 1ns;
  timeprecision 1ps;

  logic glitch_a = 1'b0;
  logic glitch_b = 1'b0;

  // A freshly enabled comparator reports the wrong level until bias settles.
  always @(posedge en_a) begin
    glitch_a = 1'b1;
    #50 glitch_a = 1'b0;
  end
  always @(posedge en_b) begin
    glitch_b = 1'b1;
    #50 glitch_b = 1'b0;
  end
  assign raw_a = en_a & (lvl_a ^ glitch_a);
  assign raw_b = en_b & (lvl_b ^ glitch_b);

  // The clocks freeze at their current level when stopped.
  initial cnt_raw = 1'b0;
  initial cnt_presc = 1'b0;
  always #35 if (run_raw) cnt_raw = ~cnt_raw;
  always @(posedge cnt_raw) if (run_presc) cnt_presc <= ~cnt_presc;
endmodule

// ---- tb/testbench.sv ----
// ============================================================================
// Bench for the comparator back end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] GI = cmp_pkg::GLOBAL_IRQ_OFS;
  localparam logic [7:0] IE = cmp_pkg::PERIPH_IE_OFS;
  localparam logic [7:0] IF = cmp_pkg::PERIPH_IF_OFS;
  localparam logic [7:0] MR = cmp_pkg::MIRROR_OFS;
  localparam logic [7:0] CC = cmp_pkg::CMP_CTRL_OFS;
  localparam logic [7:0] PC = cmp_pkg::PIN_CTRL_OFS;

  logic        REF_CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, r;
  logic        CMP_A_RAW, CMP_B_RAW, CMP_A_EN, CMP_B_EN, e;
  logic        CNT_CLK_RAW, CNT_CLK_PRESC, CNT_PRESCALE_ON;
  logic        COUNTER_GATE_PIN, COUNTER_GATE, IRQ;
  logic        CMP_A_PIN_O, CMP_A_PIN_OE, CMP_B_PIN_O, CMP_B_PIN_OE;
  logic        run_raw, run_presc;
  logic [3:0]  pins;
  // Levels at the comparators, also the software's own record.
  logic        lvl_a, lvl_b;
  int          n_errors, cmp_count, cyc;

  assign pins = {CMP_A_PIN_O, CMP_A_PIN_OE, CMP_B_PIN_O, CMP_B_PIN_OE};

  cmp_back_end cmp_back_end_inst (
    .REF_CLK(REF_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CMP_A_RAW(CMP_A_RAW),
    .CMP_B_RAW(CMP_B_RAW), .CMP_A_EN(CMP_A_EN), .CMP_B_EN(CMP_B_EN),
    .CNT_CLK_RAW(CNT_CLK_RAW), .CNT_CLK_PRESC(CNT_CLK_PRESC),
    .CNT_PRESCALE_ON(CNT_PRESCALE_ON), .COUNTER_GATE_PIN(COUNTER_GATE_PIN),
    .COUNTER_GATE(COUNTER_GATE), .CMP_A_PIN_O(CMP_A_PIN_O),
    .CMP_A_PIN_OE(CMP_A_PIN_OE), .CMP_B_PIN_O(CMP_B_PIN_O),
    .CMP_B_PIN_OE(CMP_B_PIN_OE), .IRQ(IRQ));
  analog_partner analog_partner_inst (.en_a(CMP_A_EN), .en_b(CMP_B_EN),
    .lvl_a(lvl_a), .lvl_b(lvl_b), .raw_a(CMP_A_RAW), .raw_b(CMP_B_RAW),
    .run_raw(run_raw), .run_presc(run_presc), .cnt_raw(CNT_CLK_RAW),
    .cnt_presc(CNT_CLK_PRESC));

  always #5 REF_CLK = ~REF_CLK;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask

  // The request is held until the edge that samples PREADY high.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h1, 32'h0);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    REF_CLK = 1'b0;
    SRST = 1'b1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {lvl_a, lvl_b, CNT_PRESCALE_ON, COUNTER_GATE_PIN} = '0;
    {run_raw, run_presc} = 2'h3;
    {n_errors, cmp_count, cyc} = '0;
    settle(4);
    SRST <= 1'b0;
    rd(GI, 32'h0);
    rd(IE, 32'h0);
    rd(IF, 32'h0);
    rd(MR, 32'h2);
    rd(CC, 32'h0);
    rd(PC, 32'h30);
    rd(8'h18, 32'h0);
    chk(32'(e), 32'h1);
    // ========================================================================
    // Mismatch flags
    wr(CC, 32'h3);
    settle(1);
    chk(32'({CMP_A_EN, CMP_B_EN}), 32'h3);
    settle(100);
    wr(IF, 32'h0);
    rd(CC, 32'h3);
    lvl_a <= 1'b1;
    settle(8);
    rd(MR, 32'h82);
    rd(IF, 32'h8);
    wr(IF, 32'h0);
    rd(MR, 32'h82);
    lvl_a <= 1'b0;
    settle(8);
    rd(IF, 32'h0);
    lvl_a <= 1'b1;
    settle(8);
    rd(IF, 32'h8);
    wr(IF, 32'h0);
    rd(CC, 32'h43);
    lvl_a <= 1'b0;
    settle(8);
    rd(IF, 32'h8);
    lvl_b <= 1'b1;
    settle(8);
    rd(IF, 32'h18);
    rd(MR, 32'h42);
    wr(CC, 32'hf3);
    settle(4);
    rd(CC, 32'h73);
    rd(MR, 32'h82);
    wr(CC, 32'h3);
    settle(8);
    // ========================================================================
    // Interrupt gating
    wr(IF, 32'h18);
    rd(IF, 32'h18);
    wr(IE, 32'h18);
    for (int g = 0; g < 4; g++) begin
      wr(GI, 32'(g) << 6);
      settle(3);
      chk(32'(IRQ), 32'(g == 3));
    end
    wr(IE, 32'h8);
    wr(IF, 32'h10);
    settle(3);
    chk(32'(IRQ), 32'h0);
    wr(IF, 32'h0);
    wr(GI, 32'h0);
    // ========================================================================
    // Pins
    wr(PC, 32'hc);
    settle(3);
    chk(32'(pins), 32'hf);
    wr(PC, 32'h3);
    settle(3);
    chk(32'(pins), 32'h7);
    wr(PC, 32'h33);
    settle(3);
    chk(32'({CMP_A_PIN_OE, CMP_B_PIN_OE}), 32'h0);
    // ========================================================================
    // Counter gate
    COUNTER_GATE_PIN <= 1'b1;
    settle(8);
    chk(32'(COUNTER_GATE), 32'h1);
    wr(MR, 32'hc0);
    rd(MR, 32'h40);
    lvl_b <= 1'b0;
    settle(8);
    chk(32'(COUNTER_GATE), 32'h0);
    lvl_b <= 1'b1;
    settle(20);
    run_raw <= 1'b0;
    wr(MR, 32'h1);
    settle(10);
    lvl_b <= 1'b0;
    settle(40);
    chk(32'(COUNTER_GATE), 32'h1);
    run_raw <= 1'b1;
    settle(40);
    chk(32'(COUNTER_GATE), 32'h0);
    CNT_PRESCALE_ON <= 1'b1;
    run_presc <= 1'b0;
    settle(40);
    lvl_b <= 1'b1;
    settle(40);
    chk(32'(COUNTER_GATE), 32'h0);
    run_presc <= 1'b1;
    settle(60);
    chk(32'(COUNTER_GATE), 32'h1);
    // ========================================================================
    // Reset in mid-run
    SRST <= 1'b1;
    settle(2);
    SRST <= 1'b0;
    rd(CC, 32'h0);
    chk(32'({CMP_A_EN, CMP_B_EN}), 32'h0);
    rd(MR, 32'h2);
    results();
  end
endmodule
